// ===== logic/ccr_pkg.sv
// How it works
// [R1] primary register bits 9:7 always read 3, fixed mapping kind
// [R2] primary bits 6:4 read zero; software writes them as zero
// [R3] bits 2:0 hold writable kernel segment zero attribute, reset 010
// [R4] uncached code 2: no fetch ahead, fetch stalls until instruction graduates
// [R5] cached code 3: attribute passed out, next instruction may be prefetched
// [R6] cacheable accesses may reorder; barrier or uncached access stops it
// [R7] any attribute code other than 2 or 3 behaves as 3
// [R8] register one cache geometry and entry count fields read zero
// [R9] register one bit 6 reports coprocessor two attached, 0 if unbuilt
// [R10] register one bit 4 is the performance counter build preset
// [R11] register one bits 5, 3, 2 and 0 always read zero
// [R12] register one bit 1 always reads 1, debug interface present
// [R13] register two read-only: bit 31 reads 1, bits 30:0 zero
// [R14] register three bit 31 reads 1; bits 30:28, 25:23, 9, 2 zero
// [R15] register three bits 27 and 26 read 1
// [R16] register three bits 22:21 read 1, eight-bit priority levels
// [R17] register three bits 20:18 read 010 and bit 17 reads 1
// [R18] register three bit 16 reads 0, exceptions enter standard set
// [R19] register three bits 15:14 read 2
// [R20] register three bits 13 and 5 read 1, bits 12 and 4 zero
// [R21] register three bits 11, 10, 8, 7, 3 are build presets
// [R22] register three bit 6 follows the external controller strap
// [R23] primary bits 12:10 read 010, architecture revision
// [R24] writes to read-only fields are ignored; only attribute field writable
package ccr_pkg;
   // register selects on the system-control register path
   localparam logic [2:0] SEL_PRIMARY = 3'h0;
   localparam logic [2:0] SEL_ONE = 3'h1;
   localparam logic [2:0] SEL_TWO = 3'h2;
   localparam logic [2:0] SEL_THREE = 3'h3;
   // field positions
   localparam int POS_NEXT_REG = 31;
   localparam int POS_ARCH_REV = 10;
   localparam int POS_MAP_KIND = 7;
   localparam int POS_COP2 = 6;
   localparam int POS_PERF = 4;
   localparam int POS_DEBUG = 1;
   localparam int POS_BRANCH_WORD = 27;
   localparam int POS_FAULT_WORD = 26;
   localparam int POS_PRIO_WIDTH = 21;
   localparam int POS_COMPACT_REV = 18;
   localparam int POS_CTRL_EXT = 17;
   localparam int POS_EXC_SET = 16;
   localparam int POS_ISA_AVAIL = 14;
   localparam int POS_USER_LOCAL = 13;
   localparam int POS_SIG_REV2 = 11;
   localparam int POS_SIG_EXT = 10;
   localparam int POS_TRACE = 8;
   localparam int POS_LARGE_PA = 7;
   localparam int POS_EIC = 6;
   localparam int POS_VECT_INT = 5;
   localparam int POS_DEV_MAP = 3;
   // fixed field values and reset values
   localparam logic [2:0] ARCH_REV_VAL = 3'h2;
   localparam logic [2:0] MAP_KIND_VAL = 3'h3;
   localparam logic [2:0] ATTR_UNCACHED = 3'h2;
   localparam logic [2:0] ATTR_CACHED = 3'h3;
   localparam logic [2:0] K0_RESET = 3'h2;
   localparam logic [1:0] PRIO_WIDTH_VAL = 2'h1;
   localparam logic [2:0] COMPACT_REV_VAL = 3'h2;
   localparam logic [1:0] ISA_AVAIL_VAL = 2'h2;
   localparam logic EXC_SET_RESET = 1'b0;
   // pin input indices in the synchroniser
   localparam int PIN_EIC = 0;
   localparam int PIN_COP2 = 1;

   typedef struct packed {
      logic [2:0] k0;
      logic [2:0] eff;
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] pin_q;
      logic [31:0] rd_data;
      logic rd_valid;
      logic [2:0] rd_sel;
   } ccr_state_t;
endpackage

// ===== logic/ccr_config_regs.sv
`timescale 1ns/1ps
module ccr_config_regs #(
   parameter bit COP2_IFACE_BUILT = 1'b0,
   parameter bit PERF_COUNTERS_BUILT = 1'b0,
   parameter bit SIG_EXT_REV2_BUILT = 1'b0,
   parameter bit SIG_EXT_BUILT = 1'b0,
   parameter bit FLOW_TRACE_BUILT = 1'b0,
   parameter bit LARGE_PA_BUILT = 1'b0,
   parameter bit DEV_MAP_BUILT = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cfg_rd_en,
   input wire logic cfg_wr_en,
   input wire logic [2:0] cfg_sel,
   input wire logic [31:0] cfg_wr_data,
   output logic [31:0] cfg_rd_data,
   output logic cfg_rd_valid,
   input wire logic ext_int_ctrl_strap,
   input wire logic coproc_two_attached,
   input wire logic fetch_req,
   input wire logic instr_outstanding,
   input wire logic barrier_exec,
   input wire logic uncached_access,
   output logic [2:0] coherency_attribute,
   output logic fetch_ahead_en,
   output logic ext_cacheable,
   output logic fetch_stall,
   output logic reorder_en
);
   import ccr_pkg::*;

   ccr_state_t st;
   ccr_state_t next_st;

   // assemble the word seen by a read; fields not listed read as zero
   function automatic logic [31:0] read_word(input logic [2:0] sel,
                                             input logic [2:0] k0,
                                             input logic [1:0] pins);
      logic [31:0] w;
      w = 32'h0;
      unique case (sel)
         SEL_PRIMARY: begin
            w[POS_NEXT_REG] = 1'b1;
            w[POS_ARCH_REV +: 3] = ARCH_REV_VAL; // [R23]
            w[POS_MAP_KIND +: 3] = MAP_KIND_VAL; // [R1]
            w[2:0] = k0; // bits 6:4 stay zero [R2] [R3]
         end
         SEL_ONE: begin
            // geometry, entry count and absent units stay zero [R8] [R11]
            w[POS_NEXT_REG] = 1'b1;
            w[POS_COP2] = COP2_IFACE_BUILT & pins[PIN_COP2]; // [R9]
            w[POS_PERF] = PERF_COUNTERS_BUILT; // [R10]
            w[POS_DEBUG] = 1'b1; // [R12]
         end
         SEL_TWO: begin
            w[POS_NEXT_REG] = 1'b1; // no second or third level caches [R13]
         end
         SEL_THREE: begin
            w[POS_NEXT_REG] = 1'b1; // [R14]
            w[POS_BRANCH_WORD] = 1'b1; // [R15]
            w[POS_FAULT_WORD] = 1'b1; // [R15]
            w[POS_PRIO_WIDTH +: 2] = PRIO_WIDTH_VAL; // [R16]
            w[POS_COMPACT_REV +: 3] = COMPACT_REV_VAL; // [R17]
            w[POS_CTRL_EXT] = 1'b1; // [R17]
            w[POS_EXC_SET] = EXC_SET_RESET; // [R18]
            w[POS_ISA_AVAIL +: 2] = ISA_AVAIL_VAL; // [R19]
            w[POS_USER_LOCAL] = 1'b1; // [R20]
            w[POS_VECT_INT] = 1'b1; // [R20]
            w[POS_SIG_REV2] = SIG_EXT_REV2_BUILT; // [R21]
            w[POS_SIG_EXT] = SIG_EXT_BUILT; // [R21]
            w[POS_TRACE] = FLOW_TRACE_BUILT; // [R21]
            w[POS_LARGE_PA] = LARGE_PA_BUILT; // [R21]
            w[POS_DEV_MAP] = DEV_MAP_BUILT; // [R21]
            w[POS_EIC] = pins[PIN_EIC]; // [R22]
         end
         default: w = 32'h0; // unused selects read as zero
      endcase
      return w;
   endfunction

   // next state: pin sync, attribute write, registered read answer
   always_comb begin
      next_st = st;
      // pins are asynchronous: three stages, accept when stages two and
      // three agree so a metastable first stage never reaches the fields
      next_st.s1 = {coproc_two_attached, ext_int_ctrl_strap};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < 2; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.pin_q[i] = st.s3[i]; // [R22]
         end
      end
      // only the attribute field takes written data [R24]
      if (cfg_wr_en && cfg_sel == SEL_PRIMARY) begin
         next_st.k0 = cfg_wr_data[2:0]; // [R3]
      end
      // fold unsupported codes onto cached [R7]
      if (next_st.k0 == ATTR_UNCACHED) begin
         next_st.eff = ATTR_UNCACHED;
      end else begin
         next_st.eff = ATTR_CACHED;
      end
      next_st.rd_valid = cfg_rd_en;
      next_st.rd_sel = cfg_sel;
      if (cfg_rd_en) begin
         next_st.rd_data = read_word(cfg_sel, st.k0, st.pin_q);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st.k0 <= K0_RESET; // [R3]
         st.eff <= ATTR_UNCACHED;
         st.s1 <= 2'h0;
         st.s2 <= 2'h0;
         st.s3 <= 2'h0;
         st.pin_q <= 2'h0;
         st.rd_data <= 32'h0;
         st.rd_valid <= 1'b0;
         st.rd_sel <= 3'h0;
      end else begin
         st <= next_st;
      end
   end

   assign cfg_rd_data = st.rd_data;
   assign cfg_rd_valid = st.rd_valid;
   assign coherency_attribute = st.eff;

   // cached space may look ahead and is flagged to external caches [R5]
   assign fetch_ahead_en = (st.eff == ATTR_CACHED); // [R5]
   assign ext_cacheable = (st.eff == ATTR_CACHED); // [R5]
   // uncached space waits for the outstanding instruction to graduate [R4]
   assign fetch_stall = fetch_req && (st.eff == ATTR_UNCACHED) &&
                        instr_outstanding; // [R4]
   // buffered reordering trades ordering for speed; a barrier or any
   // uncached access drops it in the same cycle [R6]
   assign reorder_en = (st.eff == ATTR_CACHED) && !barrier_exec &&
                       !uncached_access; // [R6]

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_read_of(logic [2:0] s);
      cfg_rd_en && cfg_sel == s;
   endsequence

   sequence s_strap_steady;
      $stable(ext_int_ctrl_strap) [*4];
   endsequence

   sequence s_prim_write;
      cfg_wr_en && cfg_sel == SEL_PRIMARY;
   endsequence

   // the coprocessor pin needs the same settling time as the strap
   sequence s_cop2_steady;
      $stable(coproc_two_attached) [*4];
   endsequence

   a_map_kind_fixed: assert property (s_read_of(SEL_PRIMARY) |=> // [R1]
      cfg_rd_valid && cfg_rd_data[9:7] == 3'h3)
      else $error("mapping kind field not 3");

   a_reserved_zero: assert property (s_read_of(SEL_PRIMARY) |=> // [R2]
      cfg_rd_data[6:4] == 3'h0 && cfg_rd_data[12:10] == 3'h2)
      else $error("primary reserved or revision field wrong");

   a_attr_write: assert property (s_prim_write ##1 // [R3]
      (cfg_rd_en && cfg_sel == SEL_PRIMARY && !cfg_wr_en) |=>
      cfg_rd_data[2:0] == $past(cfg_wr_data[2:0], 2))
      else $error("attribute field did not take written value");

   a_uncached_stall: assert property (fetch_req && instr_outstanding && // [R4]
      coherency_attribute == 3'h2 |-> fetch_stall && !fetch_ahead_en)
      else $error("uncached fetch not stalled");

   a_cached_ahead: assert property (coherency_attribute == 3'h3 |-> // [R5]
      fetch_ahead_en && ext_cacheable && !fetch_stall)
      else $error("cached space without look-ahead");

   a_reorder_stop: assert property (barrier_exec || uncached_access |-> // [R6]
      !reorder_en)
      else $error("reordering kept across barrier");

   a_attr_fold: assert property (cfg_wr_en && // [R7]
      cfg_sel == SEL_PRIMARY && cfg_wr_data[2:0] != 3'h2 ##1 !cfg_wr_en |->
      coherency_attribute == 3'h3)
      else $error("unsupported code not folded to cached");

   // uncached code must survive the fold unchanged
   a_attr_two_kept: assert property (cfg_wr_en && // [R4]
      cfg_sel == SEL_PRIMARY && cfg_wr_data[2:0] == 3'h2 |=>
      coherency_attribute == 3'h2)
      else $error("uncached code not kept");

   // only the two supported codes ever reach coherency_attribute
   a_attr_legal: assert property (coherency_attribute == 3'h2 || // [R7]
      coherency_attribute == 3'h3)
      else $error("effective attribute outside supported codes");

   a_ahead_pair: assert property (fetch_ahead_en == ext_cacheable) // [R5]
      else $error("look-ahead and external cacheable disagree");

   a_no_idle_stall: assert property (!fetch_req |-> !fetch_stall) // [R4]
      else $error("stall without a fetch");

   // reordering must come back once nothing forbids it
   a_reorder_back: assert property (coherency_attribute == 3'h3 && // [R6]
      !barrier_exec && !uncached_access |-> reorder_en)
      else $error("reordering not allowed in cached space");

   a_one_fixed: assert property (s_read_of(SEL_ONE) |=> // [R8]
      cfg_rd_data[31] && cfg_rd_data[30:7] == 24'h0 && cfg_rd_data[5] == 1'b0
      && cfg_rd_data[3:2] == 2'h0 && cfg_rd_data[1:0] == 2'h2)
      else $error("register one fixed fields wrong");

   a_one_presets: assert property (s_read_of(SEL_ONE) |=> // [R10]
      cfg_rd_data[4] == PERF_COUNTERS_BUILT &&
      (COP2_IFACE_BUILT || !cfg_rd_data[6]))
      else $error("register one presets wrong");

   a_two_fixed: assert property (s_read_of(SEL_TWO) |=> // [R13]
      cfg_rd_data == 32'h8000_0000)
      else $error("register two not fixed");

   // upper fixed fields plus every build preset of register three
   a_three_fixed: assert property (s_read_of(SEL_THREE) |=> // [R21]
      cfg_rd_data[31:12] == 20'h8c2aa &&
      cfg_rd_data[11] == SIG_EXT_REV2_BUILT &&
      cfg_rd_data[10] == SIG_EXT_BUILT &&
      cfg_rd_data[8] == FLOW_TRACE_BUILT &&
      cfg_rd_data[7] == LARGE_PA_BUILT &&
      cfg_rd_data[3] == DEV_MAP_BUILT)
      else $error("register three fields or presets wrong");

   a_three_fields: assert property (s_read_of(SEL_THREE) |=> // [R15]
      cfg_rd_data[31:26] == 6'h23 && cfg_rd_data[25:23] == 3'h0 &&
      cfg_rd_data[22:21] == 2'h1 && cfg_rd_data[20:17] == 4'h5 &&
      cfg_rd_data[16:12] == 5'h0a && cfg_rd_data[9] == 1'b0 &&
      cfg_rd_data[5:4] == 2'h2 && cfg_rd_data[2] == 1'b0)
      else $error("register three fixed fields wrong");

   a_strap_follow: assert property (s_strap_steady |-> // [R22]
      ##1 s_read_of(SEL_THREE) |=> cfg_rd_data[6] == $past(ext_int_ctrl_strap, 2))
      else $error("controller strap not reflected");

   a_ro_ignored: assert property (cfg_wr_en && cfg_sel != SEL_PRIMARY |=> // [R24]
      $stable(st.k0))
      else $error("write to read-only register changed state");

   // a settled coprocessor pin shows in register one only when built
   a_cop2_follow: assert property (s_cop2_steady |-> // [R9]
      ##1 s_read_of(SEL_ONE) |=>
      cfg_rd_data[6] == (COP2_IFACE_BUILT && $past(coproc_two_attached, 2)))
      else $error("coprocessor presence not reflected");

   // selects past register three have nothing behind them
   a_unused_zero: assert property (cfg_rd_en && cfg_sel > 3'h3 |=> // [R24]
      cfg_rd_data == 32'h0)
      else $error("unused select read nonzero");

   // every read answers exactly one cycle later
   a_rd_answer: assert property (cfg_rd_en |=> cfg_rd_valid) // [R24]
      else $error("read not answered");

   a_rd_single: assert property (!cfg_rd_en |=> !cfg_rd_valid) // [R24]
      else $error("read strobe without a read");

   // data stands until the next read so slow consumers may pick it late
   a_rd_hold: assert property (!cfg_rd_en |=> $stable(cfg_rd_data)) // [R24]
      else $error("read data changed without a read");

endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import ccr_pkg::*;
   localparam bit COP2_B = 1'b1;
   localparam bit PERF_B = 1'b1;
   localparam bit SIG2_B = 1'b0;
   localparam bit SIG_B = 1'b1;
   localparam bit TRACE_B = 1'b0;
   localparam bit LPA_B = 1'b1;
   localparam bit MAP_B = 1'b1;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_rd_en = 1'b0;
   logic cfg_wr_en = 1'b0;
   logic [2:0] cfg_sel = 3'h0;
   logic [31:0] cfg_wr_data = 32'h0;
   logic [31:0] cfg_rd_data;
   logic cfg_rd_valid;
   logic ext_int_ctrl_strap = 1'b0;
   logic coproc_two_attached = 1'b0;
   logic fetch_req = 1'b0;
   logic instr_outstanding = 1'b0;
   logic barrier_exec = 1'b0;
   logic uncached_access = 1'b0;
   logic [2:0] coherency_attribute;
   logic fetch_ahead_en, ext_cacheable, fetch_stall, reorder_en;
   int n_errors = 0;
   int compares = 0;
   logic [2:0] k0_model = K0_RESET;
   logic [2:0] s;

   ccr_config_regs #(.COP2_IFACE_BUILT(COP2_B), .PERF_COUNTERS_BUILT(PERF_B),
      .SIG_EXT_REV2_BUILT(SIG2_B), .SIG_EXT_BUILT(SIG_B),
      .FLOW_TRACE_BUILT(TRACE_B), .LARGE_PA_BUILT(LPA_B),
      .DEV_MAP_BUILT(MAP_B)) uut (.clock(clock), .rst_n(rst_n),
      .cfg_rd_en(cfg_rd_en), .cfg_wr_en(cfg_wr_en), .cfg_sel(cfg_sel),
      .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
      .cfg_rd_valid(cfg_rd_valid), .ext_int_ctrl_strap(ext_int_ctrl_strap),
      .coproc_two_attached(coproc_two_attached), .fetch_req(fetch_req),
      .instr_outstanding(instr_outstanding), .barrier_exec(barrier_exec),
      .uncached_access(uncached_access),
      .coherency_attribute(coherency_attribute),
      .fetch_ahead_en(fetch_ahead_en), .ext_cacheable(ext_cacheable),
      .fetch_stall(fetch_stall), .reorder_en(reorder_en));

   // expected register image, built from the field layout by hand
   function automatic logic [31:0] exp_reg(input logic [2:0] sel);
      case (sel)
         SEL_PRIMARY: return {1'b1, 18'h0, ARCH_REV_VAL, MAP_KIND_VAL, 4'h0,
            k0_model};
         SEL_ONE: return {1'b1, 24'h0, COP2_B & coproc_two_attached, 1'b0,
            PERF_B, 2'h0, 1'b1, 1'b0};
         SEL_TWO: return 32'h8000_0000;
         SEL_THREE: return {1'b1, 3'h0, 2'h3, 3'h0, PRIO_WIDTH_VAL,
            COMPACT_REV_VAL, 1'b1, EXC_SET_RESET, ISA_AVAIL_VAL, 2'h2, SIG2_B,
            SIG_B, 1'b0, TRACE_B, LPA_B, ext_int_ctrl_strap, 2'h2, MAP_B,
            3'h0};
         default: return 32'h0;
      endcase
   endfunction

   // any code but uncached behaves as cached
   function automatic logic [6:0] exp_out();
      logic a3;
      a3 = (k0_model != ATTR_UNCACHED);
      return {a3 ? ATTR_CACHED : ATTR_UNCACHED, a3, a3,
         fetch_req & !a3 & instr_outstanding,
         a3 & !barrier_exec & !uncached_access};
   endfunction

   task automatic chk_reg(input string m, input logic [31:0] g, e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic chk_out(input string m, input logic [6:0] g, e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic wr(input logic [2:0] sel, input logic [31:0] d);
      @(posedge clock);
      cfg_wr_en <= 1'b1;
      cfg_sel <= sel;
      cfg_wr_data <= d;
      @(posedge clock);
      cfg_wr_en <= 1'b0;
      if (sel == SEL_PRIMARY) k0_model = d[2:0];
   endtask

   // read data must also hold after the strobe has dropped
   task automatic rd(input logic [2:0] sel, input logic [31:0] e);
      @(posedge clock);
      cfg_rd_en <= 1'b1;
      cfg_sel <= sel;
      @(posedge clock);
      cfg_rd_en <= 1'b0;
      #1;
      chk_out("read strobe", {6'h0, cfg_rd_valid}, 7'h1);
      chk_reg("read data", cfg_rd_data, e);
      @(posedge clock);
      #1;
      chk_out("strobe length", {6'h0, cfg_rd_valid}, 7'h0);
      chk_reg("held data", cfg_rd_data, e);
   endtask

   task automatic chk_flags();
      #1;
      chk_out("fetch flags", {coherency_attribute, fetch_ahead_en,
         ext_cacheable, fetch_stall, reorder_en}, exp_out());
   endtask

   task automatic end_sim();
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial forever #4 clock = ~clock;

   // hang guard, well above the expected run length
   initial begin
      repeat (6000) @(posedge clock);
      n_errors++;
      end_sim();
   end

   initial begin
      void'($urandom(32'h49be));
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      chk_flags();
      repeat (5) @(posedge clock);
      for (int i = 0; i < 8; i++) rd(3'(i), exp_reg(3'(i)));
      for (int i = 0; i < 8; i++) wr(3'(i), 32'hffff_fff0);
      for (int i = 0; i < 4; i++) rd(3'(i), exp_reg(3'(i)));
      // every attribute code against every fetch condition
      for (int c = 0; c < 8; c++) begin
         wr(SEL_PRIMARY, 32'(c));
         for (int f = 0; f < 16; f++) begin
            @(posedge clock);
            {fetch_req, instr_outstanding, barrier_exec, uncached_access} <= 4'(f);
            chk_flags();
         end
      end
      // same-edge write and read: the read sees the old field
      @(posedge clock);
      cfg_wr_en <= 1'b1;
      cfg_rd_en <= 1'b1;
      cfg_sel <= SEL_PRIMARY;
      cfg_wr_data <= 32'h2;
      @(posedge clock);
      cfg_wr_en <= 1'b0;
      cfg_rd_en <= 1'b0;
      #1 chk_reg("same edge read", cfg_rd_data, exp_reg(SEL_PRIMARY));
      k0_model = 3'h2;
      // write then read on the next edge: the read sees the new field
      @(posedge clock);
      cfg_wr_en <= 1'b1;
      cfg_sel <= SEL_PRIMARY;
      cfg_wr_data <= 32'h5;
      @(posedge clock);
      cfg_wr_en <= 1'b0;
      cfg_rd_en <= 1'b1;
      @(posedge clock);
      cfg_rd_en <= 1'b0;
      k0_model = 3'h5;
      #1 chk_reg("next edge read", cfg_rd_data, exp_reg(SEL_PRIMARY));
      repeat (150) begin
         ext_int_ctrl_strap <= 1'($urandom);
         coproc_two_attached <= 1'($urandom);
         wr(3'($urandom), $urandom);
         repeat (4) @(posedge clock);
         {fetch_req, instr_outstanding, barrier_exec, uncached_access} <=
            4'($urandom);
         chk_flags();
         s = 3'($urandom);
         rd(s, exp_reg(s));
      end
      end_sim();
   end
endmodule
